// *** rtl/sram_host_port.sv ***
// Purpose: Host controller that drives an asynchronous two-select static RAM.
// Assumes: 40 MHz clock; read data is sampled through three flip-flops.
// Notes:   One request at a time; o_ready high means a request can be taken.
// Notes on behaviour
// - Address changes only while strobe high, deselected.
// - Recovery counted from the first ending edge.
// - No write data while RAM still drives.
// - Both selects stay active through data valid.
// - Strobe low at least float plus data valid.
// - Strobe held high for every read.
// - Address and selects valid before write end.
// - Write data valid before end, zero hold.
`timescale 1ns/10ps
`default_nettype none
module sram_host_port #(
    parameter int unsigned ADDR_WIDTH = sram_port_pkg::ADDR_WIDTH,
    parameter int unsigned DATA_WIDTH = sram_port_pkg::DATA_WIDTH
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_req,
    input  wire logic                  i_write,
    input  wire logic [ADDR_WIDTH-1:0] i_addr,
    input  wire logic [DATA_WIDTH-1:0] i_wdata,
    output logic                       o_ready,
    output logic                       o_rvalid,
    output logic [DATA_WIDTH-1:0]      o_rdata,
    output logic [ADDR_WIDTH-1:0]      o_sram_addr,
    output logic                       o_select_active_low_n,
    output logic                       o_select_active_high,
    output logic                       o_gate_n,
    output logic                       o_strobe_n,
    input  wire logic [DATA_WIDTH-1:0] i_sram_data,
    output logic [DATA_WIDTH-1:0]      o_sram_data,
    output logic                       o_sram_data_oe
);
    localparam int unsigned CW = sram_port_pkg::COUNT_WIDTH;

    // Cycle phases, one request per pass.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,  // Deselected, waiting for a request.
        ST_RDWAIT = 3'b001,  // Selected read, waiting for access time.
        ST_RDEND  = 3'b010,  // Deselect and let the RAM float.
        ST_WRLOW  = 3'b011,  // Strobe low, data driven.
        ST_WREND  = 3'b100   // Write ended, recovery before next request.
    } phase_t;

    phase_t                  state_reg,  state_next;   // Controller phase.
    logic [ADDR_WIDTH-1:0]   addr_reg,   addr_next;    // Latched address pins.
    logic [DATA_WIDTH-1:0]   wdata_reg,  wdata_next;   // Latched write byte.
    logic [DATA_WIDTH-1:0]   rdata_reg,  rdata_next;   // Captured read byte.
    logic                    rvalid_reg, rvalid_next;  // Read result pulse.
    logic                    sel_reg,    sel_next;     // Both selects active.
    logic                    gate_reg,   gate_next;    // Output gate active.
    logic                    strobe_reg, strobe_next;  // Write strobe active.
    logic                    oe_reg,     oe_next;      // Host drives data pins.
    logic [DATA_WIDTH-1:0]   sync1_reg, sync2_reg, sync3_reg; // Read data synchroniser.
    logic                    timer_load;               // Starts a phase timer.
    logic [CW-1:0]           timer_value;              // Length of the phase.
    logic                    timer_done;               // Phase time has passed.

    // Times each phase in whole clock cycles.
    sram_phase_timer #(
        .WIDTH   (CW)
    ) u_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (timer_load),
        .i_value (timer_value),
        .o_done  (timer_done)
    );

    // Computes the next phase and pin values.
    always_comb
    begin
        state_next  = state_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        rdata_next  = rdata_reg;
        rvalid_next = 1'b0;
        sel_next    = sel_reg;
        gate_next   = gate_reg;
        strobe_next = strobe_reg;
        oe_next     = oe_reg;
        timer_load  = 1'b0;
        timer_value = '0;
        case (state_reg)
            ST_IDLE:
            begin
                // Idle keeps the RAM deselected in standby.
                if (i_req && timer_done)
                begin
                    // Address moves only while deselected.
                    addr_next  = i_addr;
                    sel_next   = 1'b1;
                    timer_load = 1'b1;
                    if (i_write)
                    begin
                        // Strobe falls with select, gate stays high, so the RAM floats.
                        wdata_next  = i_wdata;
                        strobe_next = 1'b1;
                        gate_next   = 1'b0;
                        oe_next     = 1'b1;
                        timer_value = CW'(sram_port_pkg::WRITE_LOW_CYCLES);
                        state_next  = ST_WRLOW;
                    end
                    else
                    begin
                        // Read with strobe high and gate low.
                        strobe_next = 1'b0;
                        gate_next   = 1'b1;
                        timer_value = CW'(sram_port_pkg::READ_WAIT_CYCLES);
                        state_next  = ST_RDWAIT;
                    end
                end
            end
            ST_RDWAIT:
            begin
                // Data valid after access and gate times; sampled via synchroniser.
                // The byte counts only once the last two synchroniser stages agree.
                if (timer_done && (sync2_reg == sync3_reg))
                begin
                    // Address held steady until capture, so hold time is moot.
                    rdata_next  = sync3_reg;
                    rvalid_next = 1'b1;
                    sel_next    = 1'b0;
                    gate_next   = 1'b0;
                    timer_load  = 1'b1;
                    timer_value = CW'(sram_port_pkg::FLOAT_CYCLES);
                    state_next  = ST_RDEND;
                end
            end
            ST_RDEND:
            begin
                // Wait for the RAM to float after deselect.
                state_next = ST_IDLE;
            end
            ST_WRLOW:
            begin
                // Selects, address and data held until the strobe rises.
                if (timer_done)
                begin
                    strobe_next = 1'b0;
                    state_next  = ST_WREND;
                end
            end
            ST_WREND:
            begin
                // Strobe rose first; deselect and stop driving a cycle later.
                sel_next   = 1'b0;
                oe_next    = 1'b0;
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next  = ST_IDLE;
                sel_next    = 1'b0;
                gate_next   = 1'b0;
                strobe_next = 1'b0;
                oe_next     = 1'b0;
            end
        endcase
    end

    // Registers phase and pins; RAM itself needs no clock.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg  <= ST_IDLE;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
            sel_reg    <= 1'b0;
            gate_reg   <= 1'b0;
            strobe_reg <= 1'b0;
            oe_reg     <= 1'b0;
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            sync3_reg  <= '0;
        end
        else
        begin
            state_reg  <= state_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            sel_reg    <= sel_next;
            gate_reg   <= gate_next;
            strobe_reg <= strobe_next;
            oe_reg     <= oe_next;
            sync1_reg  <= i_sram_data;
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
        end
    end

    assign o_ready               = (state_reg == ST_IDLE) && timer_done;
    assign o_rvalid              = rvalid_reg;
    assign o_rdata               = rdata_reg;
    assign o_sram_addr           = addr_reg;
    assign o_select_active_low_n = !sel_reg;
    assign o_select_active_high  = sel_reg;
    assign o_gate_n              = !gate_reg;
    assign o_strobe_n            = !strobe_reg;
    assign o_sram_data           = wdata_reg;
    assign o_sram_data_oe        = oe_reg;
endmodule
`default_nettype wire

// *** shared/sram_port_pkg.sv ***
// Purpose: Shared constants for the static RAM host port controller.
// Assumes: One 40 MHz clock, period 25 ns.
// Notes:   Times are in ns; cycle counts derive from them.
package sram_port_pkg;
    localparam int unsigned CLK_PERIOD_NS           = 25;   // Clock period in ns.
    localparam int unsigned ADDR_WIDTH              = 17;   // Address inputs of the RAM.
    localparam int unsigned DATA_WIDTH              = 8;    // Data byte width.
    localparam int unsigned WORD_COUNT              = 131072; // Words held by the RAM.
    localparam int unsigned READ_ACCESS_NS          = 15;   // Address and select access time.
    localparam int unsigned GATE_ACCESS_NS          = 8;    // Output gate to valid data.
    localparam int unsigned DESELECT_TO_FLOAT_NS    = 8;    // Deselect to high impedance.
    localparam int unsigned STROBE_TO_FLOAT_NS      = 8;    // Strobe low to high impedance.
    localparam int unsigned DATA_HOLD_ADDR_NS       = 4;    // Old data held after address change.
    localparam int unsigned WRITE_PULSE_NS          = 12;   // Least strobe low time.
    localparam int unsigned ADDR_TO_END_NS          = 12;   // Address and selects before write end.
    localparam int unsigned DATA_VALID_BEFORE_END_NS = 8;   // Write data before write end.
    localparam int unsigned END_TO_DRIVE_NS         = 3;    // RAM redrive after write end.
    localparam int unsigned DESELECT_TO_STANDBY_NS  = 15;   // Deselect to standby.

    // Rounds a least time up to whole cycles, at least one.
    function automatic int unsigned min_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction

    // Read wait covers access time plus two cycles for the later synchroniser stages.
    localparam int unsigned READ_WAIT_CYCLES  = min_cycles(READ_ACCESS_NS) + 2;
    // Strobe low time covers float plus data valid, the gate-low case.
    localparam int unsigned WRITE_LOW_CYCLES  = min_cycles(STROBE_TO_FLOAT_NS + DATA_VALID_BEFORE_END_NS);
    // Float time after a read before the host drives data.
    localparam int unsigned FLOAT_CYCLES      = min_cycles(DESELECT_TO_FLOAT_NS);
    localparam int unsigned COUNT_WIDTH       = 4;      // Width of the phase counter.
endpackage

// *** rtl/sram_phase_timer.sv ***
// Purpose: Down counter that times each phase of a RAM cycle.
// Assumes: Load and count come from the controller on the same clock.
// Notes:   o_done is high while the count is zero.
`timescale 1ns/10ps
`default_nettype none
module sram_phase_timer #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_value,
    output logic                  o_done
);
    logic [WIDTH-1:0] count_reg;   // Cycles left in the phase.
    logic [WIDTH-1:0] count_next;  // Next count.

    // Loads a new phase length or counts down to zero.
    always_comb
    begin
        count_next = count_reg;
        if (i_load)
        begin
            count_next = i_value;
        end
        else if (count_reg != '0)
        begin
            count_next = count_reg - 1'b1;
        end
    end

    // Registers the count.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    // Done depends on the count alone, so a load taken on done cannot loop back into it.
    assign o_done = (count_reg == '0);
endmodule
`default_nettype wire

// *** testbench/sram_host_port_monitor.sv ***
// Purpose: Checker of the host port's RAM pin sequencing.
// Assumes: Bound to sram_host_port; one clock domain.
// Notes:   Watches design outputs plus the request inputs.
`timescale 1ns/10ps
`default_nettype none
module sram_port_checker (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_req,
    input wire logic        i_write,
    input wire logic        o_ready,
    input wire logic        o_rvalid,
    input wire logic [16:0] o_sram_addr,
    input wire logic        o_select_active_low_n,
    input wire logic        o_select_active_high,
    input wire logic        o_gate_n,
    input wire logic        o_strobe_n,
    input wire logic [7:0]  o_sram_data,
    input wire logic        o_sram_data_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_ADDR_MOVE: assert property ($changed(o_sram_addr) |-> $past(o_strobe_n) && $past(o_select_active_low_n))
        else $error("address moved while selected");
    AST_SEL_PAIR: assert property (o_select_active_low_n == !o_select_active_high)
        else $error("selects split");
    AST_NO_CLASH: assert property (o_sram_data_oe |-> o_gate_n)
        else $error("host drives while gate open");
    AST_PULSE: assert property ($fell(o_strobe_n) |-> o_sram_data_oe ##1 !o_strobe_n)
        else $error("strobe pulse short");
    AST_END_SEL: assert property ($rose(o_strobe_n) |-> !o_select_active_low_n && o_sram_data_oe && $stable(o_sram_data))
        else $error("write ended unselected or with moving data");
    AST_RECOVER: assert property ($rose(o_strobe_n) |=> o_select_active_low_n && !o_sram_data_oe)
        else $error("no recovery after write");
    AST_READ_ANSWER: assert property (i_req && o_ready && !i_write |-> ##5 o_rvalid)
        else $error("read answer late");
    AST_READ_SEL: assert property (i_req && o_ready && !i_write |=> (!o_select_active_low_n && !o_gate_n && o_strobe_n) [*4] ##1 o_select_active_low_n)
        else $error("read window wrong");
    // Main scenarios: read, write, refused request.
    cover property ($rose(o_rvalid));
    cover property ($fell(o_strobe_n));
    cover property (i_req && !o_ready);
endmodule
bind sram_host_port sram_port_checker chk (.i_clk, .i_rst, .i_req, .i_write, .o_ready, .o_rvalid, .o_sram_addr,
    .o_select_active_low_n, .o_select_active_high, .o_gate_n, .o_strobe_n, .o_sram_data, .o_sram_data_oe);
`default_nettype wire

// *** testbench/sram_device_model.sv ***
// Purpose: Behavioural two-select 128K x 8 static RAM.
// Assumes: The bench merges host and RAM drive into one byte.
// Notes:   Released pins show the inverse of the last byte.
`timescale 1ns/10ps
`default_nettype none
module sram_device_model (
    input  wire logic [16:0] i_addr,
    input  wire logic        i_sel_n,
    input  wire logic        i_sel,
    input  wire logic        i_gate_n,
    input  wire logic        i_strobe_n,
    input  wire logic [7:0]  i_bus,
    output logic      [7:0]  o_data,
    output logic             o_drive
);
    logic [7:0] mem [0:131071]; // Storage without clock or refresh.
    logic [7:0] last;           // Last byte driven.
    logic       chosen;         // Both selects active.
    assign chosen = !i_sel_n && i_sel;
    // Write during the overlap of both selects and a low strobe.
    always @* if (chosen && !i_strobe_n) mem[i_addr] = i_bus;
    // Drive only in a selected read with the gate low, floating within 8 ns otherwise.
    assign #8 o_drive = chosen && i_strobe_n && !i_gate_n;
    always @(o_drive or i_addr) if (o_drive) last = mem[i_addr];
    assign o_data = o_drive ? last : ~last;
endmodule
`default_nettype wire

// *** testbench/sram_host_port_test.sv ***
// Purpose: Self-checking bench of the RAM host port.
// Assumes: 40 MHz clock, RAM model on the pins.
// Notes:   Random writes with read-back, plus corner addresses.
`timescale 1ns/10ps
`default_nettype none
module sram_host_port_test;
    logic        i_clk, i_rst, i_req, i_write, ready, rvalid, sel_n, sel, gate_n, strobe_n, oe, ram_drive;
    logic [16:0] i_addr, sram_addr, a;
    logic [7:0]  i_wdata, rdata, wpin, ram_data, d;
    wire  [7:0]  bus;
    logic [7:0]  shadow [logic [16:0]]; // Expected memory contents.
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          seed = 13997;
    sram_host_port dut (.i_clk, .i_rst, .i_req, .i_write, .i_addr, .i_wdata, .o_ready(ready), .o_rvalid(rvalid),
        .o_rdata(rdata), .o_sram_addr(sram_addr), .o_select_active_low_n(sel_n), .o_select_active_high(sel),
        .o_gate_n(gate_n), .o_strobe_n(strobe_n), .i_sram_data(bus), .o_sram_data(wpin), .o_sram_data_oe(oe));
    sram_device_model ram (.i_addr(sram_addr), .i_sel_n(sel_n), .i_sel(sel), .i_gate_n(gate_n),
        .i_strobe_n(strobe_n), .i_bus(bus), .o_data(ram_data), .o_drive(ram_drive));
    // Two drivers at once give an unknown byte.
    assign bus = (oe && ram_drive) ? 8'hxx : (oe ? wpin : ram_data);
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] want);
        n_compared++;
        if (seen !== want)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    function automatic logic [7:0] expect_byte(input logic [16:0] ad);
        return shadow[ad];
    endfunction
    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Holds one request until taken; a read then checks latency and byte.
    task automatic xfer(input logic w, input logic [16:0] ad, input logic [7:0] wd);
        int n;
        @(posedge i_clk);
        i_req <= 1'b1;
        i_write <= w;
        i_addr <= ad;
        i_wdata <= wd;
        @(negedge i_clk);
        for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge i_clk);
        @(posedge i_clk);
        i_req <= 1'b0;
        if (!w)
        begin
            for (n = 0; n < 9; n++)
            begin
                @(negedge i_clk);
                if (rvalid === 1'b1) break;
            end
            check("read latency", 17'(n), 17'd4);
            check("read byte", 17'(rdata), 17'(expect_byte(ad)));
        end
    endtask
    // Cuts a hang short.
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            complete_run;
        end
    end
    initial
    begin
        i_rst = 1'b1;
        i_req = 1'b0;
        i_write = 1'b0;
        i_addr = 17'h0;
        i_wdata = 8'h0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        check("idle pins", 17'({ready, strobe_n, sel_n, sel, gate_n, oe}), 17'h3a);
        shadow[17'h0] = 8'h5a;
        shadow[17'h1ffff] = 8'hff;
        xfer(1'b1, 17'h0, 8'h00);
        xfer(1'b1, 17'h1ffff, 8'hff);
        xfer(1'b1, 17'h0, 8'h5a);
        repeat (40)
        begin
            a = 17'($random(seed));
            d = 8'($random(seed));
            shadow[a] = d;
            xfer(1'b1, a, d);
            xfer(1'b0, a, 8'h0);
        end
        foreach (shadow[x]) xfer(1'b0, x, 8'h0);
        complete_run;
    end
endmodule
`default_nettype wire
